/* core/audio_out_buffer_dma_control.sv */
// Double-buffered audio output DMA control with AXI4-Lite registers.
// Assumes a sample request pulse from the serial side, a fetch interface
// to SDRAM, and an asynchronous global powerdown input.
`timescale 1ns/1ns
module audio_out_buffer_dma_control
  import ao_dma_pkg::*;
#(
  parameter int SIZE_W = 32
) (
  // Clock, reset, clock enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial side events (same clock)
  input wire logic sample_req,
  input wire logic last_sample_out,
  input wire logic fetch_late,
  // Fetch address toward SDRAM
  output logic [31:0] fetch_addr,
  output logic fetch_active,
  // System inputs (pins)
  input wire logic global_powerdown,
  input wire logic cycle_count_select,
  // Status to the serial side and processor
  output logic serial_freeze,
  output logic irq
);
  // Elaboration check
  initial begin
    if (SIZE_W < ALIGN_BITS + 1 || SIZE_W > 32) begin
      $error("SIZE_W out of range");
    end
  end

  // Register state
  logic [31:0] ctrl;             // Control word
  logic [31:0] first_buffer_start;
  logic [31:0] second_buffer_start;
  logic [SIZE_W-1:0] buf_size;
  logic [31:0] last_buffer_sent_time;
  // Status flags
  logic first_buffer_current;
  logic first_buffer_drained;
  logic second_buffer_drained;
  logic fetch_bandwidth_error;
  logic starvation;
  // Engine
  eng_state_type state;
  logic [SIZE_W-1:0] remain;     // Samples left in current buffer
  logic [31:0] cycle_count;
  logic pd_sync, sel_sync;
  // Bus handshake holding
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Pin inputs through two flops
  sync2 u_pd (.mclk(mclk), .rst_n(rst_n), .din(global_powerdown), .dout(pd_sync));
  sync2 u_sel (.mclk(mclk), .rst_n(rst_n), .din(cycle_count_select), .dout(sel_sync));

  cycle_counter #(.WIDTH(32)) u_cc (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .count_en(sel_sync), .count(cycle_count)
  );

  // Decoded control bits
  logic transmit_on, stay_awake;
  assign transmit_on = ctrl[CTL_TRANSMIT];
  assign stay_awake = ctrl[CTL_STAY];

  // powerdown only when not staying awake
  logic asleep;
  assign asleep = pd_sync && !stay_awake;
  logic run_ce;
  assign run_ce = ce && !asleep;

  // Accepted write this cycle
  logic wr_go;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  logic wr_ctrl;
  assign wr_ctrl = wr_go && aw_addr == OFF_CTRL && w_strb == 4'hF;
  logic refill1, refill2, ackbw, ackudr, soft_reset;
  assign refill1 = wr_ctrl && w_data[CTL_REFILL1];
  assign refill2 = wr_ctrl && w_data[CTL_REFILL2];
  assign ackbw = wr_ctrl && w_data[CTL_ACKBW];
  assign ackudr = wr_ctrl && w_data[CTL_ACKUDR];
  assign soft_reset = wr_ctrl && w_data[CTL_RESET];

  // Buffer events
  logic take, drain_now, drain1, drain2, full_next;
  // Samples count only while transmitting, so a drain switches buffers unless a soft reset comes in the same cycle
  assign take = state == ST_RUN && transmit_on && sample_req && run_ce;
  assign drain_now = take && remain == {{(SIZE_W-1){1'b0}}, 1'b1};
  assign drain1 = drain_now && first_buffer_current;
  assign drain2 = drain_now && !first_buffer_current;
  // Next buffer full when its drained flag is clear
  assign full_next = first_buffer_current ? !second_buffer_drained : !first_buffer_drained;

  // Write channel capture, AW and W in either order
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Ready and response registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      // Each ready only while its own channel holds nothing, one cycle per beat
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        // Unmapped or read-only target answers with an error
        if (aw_addr == OFF_CTRL || aw_addr == OFF_FIRST_START || aw_addr == OFF_SECOND_START
            || aw_addr == OFF_SIZE) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable registers; partial writes to control are ignored
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
      first_buffer_start <= ADDR_RESET;
      second_buffer_start <= ADDR_RESET;
      buf_size <= '0;
    end else if (ce) begin
      if (soft_reset) begin
        ctrl <= CTRL_RESET;
        first_buffer_start <= ADDR_RESET;
        second_buffer_start <= ADDR_RESET;
        buf_size <= '0;
      end else if (wr_go) begin
        // enables reset to zero, set by write
        if (wr_ctrl) begin
          ctrl <= {26'h0, w_data[CTL_IEUDR:CTL_TRANSMIT]};
        end else if (aw_addr == OFF_FIRST_START) begin
          first_buffer_start <= w_data;
        end else if (aw_addr == OFF_SECOND_START) begin
          second_buffer_start <= w_data;
        end else if (aw_addr == OFF_SIZE) begin
          buf_size <= w_data[SIZE_W-1:0];
        end
      end
    end
  end

  // Drained flags: a drain in the ack cycle wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      first_buffer_drained <= 1'b0;
      second_buffer_drained <= 1'b0;
    end else if (ce) begin
      if (soft_reset) begin
        first_buffer_drained <= 1'b0;
        second_buffer_drained <= 1'b0;
      end else begin
        // set on drain, clear on acknowledge
        if (drain1) begin
          first_buffer_drained <= 1'b1;
        end else if (refill1) begin
          first_buffer_drained <= 1'b0;
        end
        if (drain2) begin
          second_buffer_drained <= 1'b1;
        end else if (refill2) begin
          second_buffer_drained <= 1'b0;
        end
      end
    end
  end

  // Error flags, sticky until their own strobe or a soft reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_bandwidth_error <= 1'b0;
      starvation <= 1'b0;
    end else if (ce) begin
      if (soft_reset) begin
        fetch_bandwidth_error <= 1'b0;
        starvation <= 1'b0;
      end else begin
        if (state == ST_RUN && fetch_late && run_ce) begin
          fetch_bandwidth_error <= 1'b1;
        end else if (ackbw) begin
          fetch_bandwidth_error <= 1'b0;
        end
        if (state == ST_STARVE && sample_req && run_ce) begin
          starvation <= 1'b1;
        end else if (ackudr) begin
          starvation <= 1'b0;
        end
      end
    end
  end

  // Buffer engine
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      first_buffer_current <= 1'b1;
      remain <= '0;
      fetch_addr <= 32'h0000_0000;
    end else if (ce) begin
      if (soft_reset) begin
        state <= ST_IDLE;
        first_buffer_current <= 1'b1;
        remain <= '0;
        fetch_addr <= 32'h0000_0000;
      end else if (!asleep) begin
        case (state)
          ST_IDLE: begin
            if (transmit_on) begin
              state <= ST_RUN;
              remain <= buf_size;
              fetch_addr <= first_buffer_current ? first_buffer_start : second_buffer_start;
            end
          end
          ST_RUN: begin
            if (!transmit_on) begin
              state <= ST_IDLE;
            end else if (drain_now) begin
              first_buffer_current <= !first_buffer_current;
              remain <= buf_size;
              fetch_addr <= first_buffer_current ? second_buffer_start : first_buffer_start;
              if (!full_next) begin
                state <= ST_STARVE;
              end
            end else if (take) begin
              remain <= remain - {{(SIZE_W-1){1'b0}}, 1'b1};
            end
          end
          ST_STARVE: begin
            // Resume once the awaited buffer is acknowledged
            if (!transmit_on) begin
              state <= ST_IDLE;
            end else if ((first_buffer_current && refill1) || (!first_buffer_current && refill2)) begin
              state <= ST_RUN;
              remain <= buf_size;
              fetch_addr <= first_buffer_current ? first_buffer_start : second_buffer_start;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // timestamp of the last sample of a finished buffer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      last_buffer_sent_time <= 32'h0000_0000;
    end else if (ce) begin
      if (last_sample_out) begin
        last_buffer_sent_time <= cycle_count;
      end
    end
  end

  // Outputs from flops: interrupt, freeze, fetch active
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
      serial_freeze <= 1'b0;
      fetch_active <= 1'b0;
    end else if (ce) begin
      irq <= (first_buffer_drained && ctrl[CTL_IE1]) || (second_buffer_drained && ctrl[CTL_IE2])
          || (fetch_bandwidth_error && ctrl[CTL_IEBW]) || (starvation && ctrl[CTL_IEUDR]);
      // serial side holds its levels while frozen
      serial_freeze <= asleep;
      fetch_active <= state == ST_RUN && !asleep;
    end
  end

  // Read channel
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr == OFF_CTRL) begin
      rd_word = ctrl;
    end else if (s_axi_araddr == OFF_STAT) begin
      rd_word = {27'h0, starvation, fetch_bandwidth_error, second_buffer_drained,
                 first_buffer_drained, first_buffer_current};
    end else if (s_axi_araddr == OFF_FIRST_START) begin
      rd_word = first_buffer_start;
    end else if (s_axi_araddr == OFF_SECOND_START) begin
      rd_word = second_buffer_start;
    end else if (s_axi_araddr == OFF_SIZE) begin
      rd_word = 32'(buf_size);
    end else if (s_axi_araddr == OFF_TSTAMP) begin
      rd_word = last_buffer_sent_time;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Assertions
  property p_ack_clears;
    @(posedge mclk) disable iff (!rst_n) (ce && refill1 && !drain1) |=> !first_buffer_drained;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear first drained");
  property p_drain2;
    @(posedge mclk) disable iff (!rst_n) (ce && drain2 && !soft_reset) |=> second_buffer_drained && first_buffer_current;
  endproperty
  a_drain2: assert property (p_drain2) else $error("second drain not handled");
  property p_drain1;
    @(posedge mclk) disable iff (!rst_n) (ce && drain1 && !soft_reset) |=> first_buffer_drained && !first_buffer_current;
  endproperty
  a_drain1: assert property (p_drain1) else $error("first drain not handled");
  property p_udr_sticky;
    @(posedge mclk) disable iff (!rst_n) (starvation && !ackudr && !soft_reset) |=> starvation;
  endproperty
  a_udr_sticky: assert property (p_udr_sticky) else $error("starvation lost");
  property p_bw_sticky;
    @(posedge mclk) disable iff (!rst_n) (fetch_bandwidth_error && !ackbw && !soft_reset) |=> fetch_bandwidth_error;
  endproperty
  a_bw_sticky: assert property (p_bw_sticky) else $error("bandwidth error lost");
  property p_irq;
    @(posedge mclk) disable iff (!rst_n) ce |=> irq == $past((first_buffer_drained && ctrl[CTL_IE1])
      || (second_buffer_drained && ctrl[CTL_IE2]) || (fetch_bandwidth_error && ctrl[CTL_IEBW])
      || (starvation && ctrl[CTL_IEUDR]));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt mismatch");
  property p_soft_reset;
    @(posedge mclk) disable iff (!rst_n) (ce && soft_reset) |=> state == ST_IDLE && first_buffer_current && ctrl == CTRL_RESET;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");
  property p_idle_off;
    @(posedge mclk) disable iff (!rst_n) (ce && !asleep && !transmit_on) |=> state == ST_IDLE;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("engine ran while disabled");
endmodule

/* core/ao_dma_pkg.sv */
// Package for the audio output buffer DMA control block.
// Assumes a 32-bit AXI4-Lite register bus and one 125 MHz processor clock.
package ao_dma_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;   // Control and enables
  localparam logic [7:0] OFF_STAT = 8'h04;   // Status flags
  localparam logic [7:0] OFF_FIRST_START = 8'h08;  // First buffer start
  localparam logic [7:0] OFF_SECOND_START = 8'h0C; // Second buffer start
  localparam logic [7:0] OFF_SIZE = 8'h10;   // Buffer size in samples
  localparam logic [7:0] OFF_TSTAMP = 8'h14; // Last buffer sent time
  // Control field positions
  localparam int CTL_TRANSMIT = 0;
  localparam int CTL_STAY = 1;
  localparam int CTL_IE1 = 2;
  localparam int CTL_IE2 = 3;
  localparam int CTL_IEBW = 4;
  localparam int CTL_IEUDR = 5;
  localparam int CTL_REFILL1 = 6;
  localparam int CTL_REFILL2 = 7;
  localparam int CTL_ACKBW = 8;
  localparam int CTL_ACKUDR = 9;
  localparam int CTL_RESET = 31;
  // Status field positions
  localparam int ST_CUR1 = 0;
  localparam int ST_E1 = 1;
  localparam int ST_E2 = 2;
  localparam int ST_BW = 3;
  localparam int ST_UDR = 4;
  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  // Alignment: six low bits of base and size are zero
  localparam int ALIGN_BITS = 6;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_STARVE = 3'b100
  } eng_state_type;
endpackage

/* core/sync2.sv */
// Two flip-flop synchroniser for one level.
// Assumes the input is asynchronous to mclk.
`timescale 1ns/1ns
module sync2 (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Level in and out
  input wire logic din,
  output logic dout
);
  logic meta; // First stage, read only by the second
  // Two stages, no logic between
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

/* core/cycle_counter.sv */
// Free running processor cycle counter used for timestamps.
// Assumes it is cleared by its own reset, never by the unit reset.
`timescale 1ns/1ns
module cycle_counter #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Counting control
  input wire logic ce,
  input wire logic count_en,
  // Count value
  output logic [WIDTH-1:0] count
);
  // Check width
  initial begin
    if (WIDTH < 1) begin
      $error("cycle_counter width too small");
    end
  end
  // Never powers down: only the clock enable and select gate it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (ce && count_en) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule

/* verif/ao_dac_model.sv */
// Model of the converter and SDRAM fetch side of the audio output block.
// Assumes the block samples these events on the rising edge of mclk.
`timescale 1ns/1ns
module ao_dac_model (
  // Clock
  input wire logic mclk,
  // Events toward the block
  output logic sample_req,
  output logic last_sample_out,
  output logic fetch_late
);
  // Quiet lines until a task runs
  initial begin
    sample_req = 1'b0;
    last_sample_out = 1'b0;
    fetch_late = 1'b0;
  end

  // Request n samples; gap adds idle cycles to model a slow converter
  task automatic pull(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      sample_req <= 1'b1;
      last_sample_out <= (i == n - 1);
      @(posedge mclk);
      sample_req <= 1'b0;
      last_sample_out <= 1'b0;
      repeat (gap) @(posedge mclk);
    end
  endtask

  // One late refill of the internal fetch buffer
  task automatic flag_late;
    @(posedge mclk);
    fetch_late <= 1'b1;
    @(posedge mclk);
    fetch_late <= 1'b0;
  endtask
endmodule

/* verif/test_audio_out_buffer_dma_control.sv */
// Self-checking bench for the audio output DMA control block.
// Assumes a 125 MHz mclk, async low reset and the converter model.
`timescale 1ns/1ns
module test_audio_out_buffer_dma_control;
  import ao_dma_pkg::*;
  logic mclk, rst_n, ce, gpd, ccs, frz, irq, fact, sreq, lso, late;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, faddr;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int num_errors = 0;
  int total_checks = 0;
  logic [31:0] ticks = 32'h0;  // Edges since reset release
  logic [31:0] lso_at = 32'h0; // Expected time of the last finished buffer

  // bench cycle count; the select pin passes two flops before the counter sees it
  always @(posedge mclk) begin
    if (rst_n) ticks <= ticks + 32'h1;
    if (lso) lso_at <= ticks - 32'h2;
  end

  audio_out_buffer_dma_control dut (
    .mclk(mclk), .rst_n(rst_n), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample_req(sreq), .last_sample_out(lso), .fetch_late(late),
    .fetch_addr(faddr), .fetch_active(fact),
    .global_powerdown(gpd), .cycle_count_select(ccs),
    .serial_freeze(frz), .irq(irq)
  );

  ao_dac_model dac (.mclk(mclk), .sample_req(sreq), .last_sample_out(lso), .fetch_late(late));

  // 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Verdict and end of run
  task automatic finish_test;
    if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Value compare
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask

  // A wait that used its bound ends the run
  task automatic expire(input int n);
    if (n >= 50) begin
      chk("wait_bound", 32'h0, 32'h1);
      finish_test();
    end
  endtask

  // Single bit at position p
  function automatic logic [31:0] b(input int p);
    return 32'h1 << p;
  endfunction

  // AXI4-Lite write; address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ad, dd;
    n = 0;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && dd) && n < 50) begin
      @(negedge mclk);
      ad = ad | awready;
      dd = dd | wready;
      @(posedge mclk);
      if (ad) awvalid <= 1'b0;
      if (dd) wvalid <= 1'b0;
      n++;
    end
    expire(n);
    do begin
      @(negedge mclk);
      n++;
    end while (!bvalid && n < 50);
    expire(n);
    chk("bresp", er, bresp);
    @(posedge mclk);
    bready <= 1'b0;
    @(negedge mclk);
  endtask

  // AXI4-Lite read with data and response compare
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge mclk);
      n++;
    end while (!arready && n < 50);
    @(posedge mclk);
    arvalid <= 1'b0;
    while (!rvalid && n < 50) begin
      @(negedge mclk);
      n++;
    end
    expire(n);
    chk($sformatf("reg_%h", a), e, rdata);
    chk("rresp", er, rresp);
    @(posedge mclk);
    rready <= 1'b0;
    @(negedge mclk);
  endtask

  // Transmit plus all four interrupt enables
  localparam logic [31:0] EN = (32'h1 << CTL_TRANSMIT) | (32'h1 << CTL_IE1) | (32'h1 << CTL_IE2)
    | (32'h1 << CTL_IEBW) | (32'h1 << CTL_IEUDR);

  // Main sequence
  initial begin
    int n;
    {rst_n, gpd, awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    ce = 1'b1;
    ccs = 1'b1;
    wstrb = 4'hF;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(OFF_STAT, b(ST_CUR1), RESP_OKAY);
    rd(OFF_CTRL, 32'h0, RESP_OKAY);
    chk("irq", 32'h0, irq);
    wr(OFF_FIRST_START, 32'h0000_1000, RESP_OKAY);
    wr(OFF_SECOND_START, 32'h0000_2000, RESP_OKAY);
    wr(OFF_SIZE, 32'h0000_0040, RESP_OKAY);
    wr(OFF_CTRL, EN, RESP_OKAY);
    rd(OFF_CTRL, EN, RESP_OKAY);
    chk("fetch_addr", 32'h0000_1000, faddr);
    chk("fetch_active", 32'h1, fact);
    dac.pull(64, 0);
    rd(OFF_STAT, b(ST_E1), RESP_OKAY);
    chk("fetch_addr", 32'h0000_2000, faddr);
    chk("irq", 32'h1, irq);
    rd(OFF_TSTAMP, lso_at, RESP_OKAY);
    wr(OFF_CTRL, EN | b(CTL_REFILL1), RESP_OKAY);
    rd(OFF_STAT, 32'h0, RESP_OKAY);
    chk("irq", 32'h0, irq);
    rd(OFF_CTRL, EN, RESP_OKAY);
    dac.pull(64, 3);
    rd(OFF_STAT, b(ST_CUR1) | b(ST_E2), RESP_OKAY);
    chk("fetch_addr", 32'h0000_1000, faddr);
    rd(OFF_TSTAMP, lso_at, RESP_OKAY);
    wr(OFF_CTRL, EN | b(CTL_REFILL2), RESP_OKAY);
    rd(OFF_STAT, b(ST_CUR1), RESP_OKAY);
    dac.flag_late();
    rd(OFF_STAT, b(ST_CUR1) | b(ST_BW), RESP_OKAY);
    wr(OFF_CTRL, EN & ~b(CTL_IEBW), RESP_OKAY);
    chk("irq", 32'h0, irq);
    wr(OFF_CTRL, EN, RESP_OKAY);
    chk("irq", 32'h1, irq);
    wr(OFF_CTRL, EN | b(CTL_ACKBW), RESP_OKAY);
    rd(OFF_STAT, b(ST_CUR1), RESP_OKAY);
    // Both buffers drain unacknowledged, then one more request starves
    dac.pull(128, 0);
    dac.pull(1, 0);
    rd(OFF_STAT, b(ST_CUR1) | b(ST_E1) | b(ST_E2) | b(ST_UDR), RESP_OKAY);
    chk("irq", 32'h1, irq);
    wr(OFF_CTRL, EN | b(CTL_REFILL1), RESP_OKAY);
    rd(OFF_STAT, b(ST_CUR1) | b(ST_E2) | b(ST_UDR), RESP_OKAY);
    wr(OFF_CTRL, EN | b(CTL_REFILL2) | b(CTL_ACKUDR), RESP_OKAY);
    rd(OFF_STAT, b(ST_CUR1), RESP_OKAY);
    rd(8'h18, 32'h0, RESP_SLVERR);
    wr(OFF_STAT, 32'h0, RESP_SLVERR);
    // Clock enable low freezes the engine: these requests must not count
    @(posedge mclk);
    ce <= 1'b0;
    dac.pull(8, 0);
    @(posedge mclk);
    ce <= 1'b1;
    dac.pull(63, 0);
    rd(OFF_STAT, b(ST_CUR1), RESP_OKAY);
    dac.pull(1, 0);
    rd(OFF_STAT, b(ST_E1), RESP_OKAY);
    // Powerdown freezes the serial side unless kept awake
    @(posedge mclk);
    gpd <= 1'b1;
    n = 0;
    while (!frz && n < 50) begin
      @(negedge mclk);
      n++;
    end
    expire(n);
    chk("serial_freeze", 32'h1, frz);
    wr(OFF_CTRL, EN | b(CTL_STAY), RESP_OKAY);
    n = 0;
    while (frz && n < 50) begin
      @(negedge mclk);
      n++;
    end
    expire(n);
    chk("serial_freeze", 32'h0, frz);
    @(posedge mclk);
    gpd <= 1'b0;
    wr(OFF_CTRL, b(CTL_RESET), RESP_OKAY);
    rd(OFF_CTRL, 32'h0, RESP_OKAY);
    rd(OFF_FIRST_START, 32'h0, RESP_OKAY);
    rd(OFF_STAT, b(ST_CUR1), RESP_OKAY);
    chk("fetch_active", 32'h0, fact);
    finish_test();
  end
endmodule
